// file: hdl/pmc_pkg.sv
// Constants for the manufacturer command register bank.
package pmc_pkg;
    // Command codes.
    localparam logic [7:0] CMD_SPEC_REVISION = 8'h98;
    localparam logic [7:0] CMD_MAKER_CODE    = 8'h99;
    localparam logic [7:0] CMD_MODEL_CODE    = 8'h9a;
    localparam logic [7:0] CMD_PART_REVISION = 8'h9b;
    localparam logic [7:0] CMD_LINK_ECHO     = 8'hd0;
    localparam logic [7:0] CMD_MODE_CONFIG   = 8'hd1;
    localparam logic [7:0] CMD_TRIM_RATE     = 8'hd2;
    localparam logic [7:0] CMD_MONITOR_RATE  = 8'hd3;
    localparam logic [7:0] CMD_VOLT_PEAK     = 8'hd4;
    localparam logic [7:0] CMD_CURR_PEAK     = 8'hd5;
    localparam logic [7:0] CMD_TEMP_PEAK     = 8'hd6;
    localparam logic [7:0] CMD_AVERAGING     = 8'hd7;
    // Mode word field positions.
    localparam int MODE_CLK_FACTOR_LSB = 8;
    localparam int MODE_CLK_OUT        = 7;
    localparam int MODE_PIN_ONOFF      = 6;
    localparam int MODE_STORE_LOCK     = 5;
    localparam int MODE_CORR_BYPASS    = 4;
    localparam int MODE_RANGE_HIGH     = 3;
    localparam int MODE_EN_POLARITY    = 2;
    localparam int MODE_FEEDBACK       = 1;
    localparam int MODE_EXT_CLOCK      = 0;
    // Reset values.
    localparam logic [15:0] MODE_RESET      = 16'h0000;
    localparam logic [15:0] TRIM_RATE_RESET = 16'h000a;
    localparam logic [15:0] MON_RATE_RESET  = 16'h0032;
    localparam logic [15:0] PEAK_RESET      = 16'h0000;
    localparam logic [15:0] AVG_RESET       = 16'h0000;
    localparam logic [15:0] TEMP_PEAK_CLEAR = 16'hffff;
    localparam logic [15:0] TEMP_PEAK_LOW   = 16'h8000;
    // Spec revision fields: part one in [7:5], part two in [4:0].
    localparam logic [2:0] SPEC_PART1_REV = 3'h0;
    localparam logic [4:0] SPEC_PART2_REV = 5'h00;
    // Timing.
    localparam int CLK_PERIOD_NS   = 100;
    localparam int TICK_PERIOD_NS  = 100000;
    localparam int TICK_CYCLES     = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int REFCLK_PERIOD_NS = 1000;
    localparam int REFCLK_HALF     = (REFCLK_PERIOD_NS / 2 + CLK_PERIOD_NS
                                      - 1) / CLK_PERIOD_NS;
    localparam int DELAY_BASE_PS   = 1750000;
    localparam int DELAY_STEP_PS   = 250000;
    localparam int EXT_FACTOR_MIN  = 8;
    localparam int EXT_FACTOR_MAX  = 248;
    localparam int EXT_FACTOR_BIAS = 2;
endpackage

// file: hdl/pmc_command_bank.sv
// Manufacturer command register bank with timebase, dividers and peaks.
`timescale 1ns/1ps
module pmc_command_bank
    import pmc_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE    = 16'h1234, // Arbitrary value.
    parameter logic [15:0] MODEL_CODE    = 16'h5678, // Arbitrary value.
    parameter logic [15:0] REVISION_TEXT = 16'h4130  // Arbitrary value.
)
(
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Command port from the bus slave.
    input  wire logic        cmd_wr,
    input  wire logic        cmd_rd,
    input  wire logic        cmd_block,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic      [15:0] cmd_rdata,
    output logic             cmd_ack,
    // Store and restore requests.
    input  wire logic        store_all_req,
    input  wire logic        restore_all_req,
    output logic             eeprom_store_go,
    output logic             eeprom_restore_go,
    // Measurements.
    input  wire logic        meas_valid,
    input  wire logic [15:0] meas_voltage,
    input  wire logic [15:0] meas_current,
    input  wire logic [15:0] meas_temp,
    // Supply control.
    input  wire logic        operation_on,
    input  wire logic        in_regulation,
    output logic             supply_enable_output,
    output logic             trim_step,
    output logic             monitor_tick,
    // Shared pins.
    input  wire logic        shared_timebase_pin_in,
    output logic             shared_timebase_pin_out,
    output logic             shared_timebase_pin_oe,
    input  wire logic        addr_or_power_switch_pin,
    // Mode outputs.
    output logic             corr_bypass,
    output logic             range_high,
    output logic             feedback_mode,
    output logic [7:0]       avg_delay_code,
    output logic [7:0]       avg_count_exp
);

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [15:0] link_echo_word;
    logic [15:0] device_mode_config;
    logic [15:0] dac_trim_rate_divider;
    logic [15:0] monitor_rate_divider;
    logic [15:0] voltage_peak_hold;
    logic [15:0] current_peak_hold;
    logic [15:0] temperature_peak_hold;
    logic [15:0] averaging_config;

    // Decoded write strobe for one command code.
    function automatic logic wr_hit(input logic [7:0] code);
        return cmd_wr && (cmd_code == code);
    endfunction

    // Peak update keeps the larger of held and measured value.
    function automatic logic [15:0] peak_of(input logic [15:0] held,
                                            input logic [15:0] meas,
                                            input logic        signed_cmp);
        if (signed_cmp)
            return ($signed(meas) > $signed(held)) ? meas : held;
        return (meas > held) ? meas : held;
    endfunction

    // Echo captures the data word of every write, echo or not.
    always_ff @(posedge core_clk)
    begin
        if (rst)
            link_echo_word <= 16'h0000;
        else if (cmd_wr)
            link_echo_word <= cmd_wdata;
    end

    // Mode and rate registers.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            device_mode_config    <= MODE_RESET;
            dac_trim_rate_divider <= TRIM_RATE_RESET;
            monitor_rate_divider  <= MON_RATE_RESET;
            averaging_config      <= AVG_RESET;
        end
        else
        begin
            if (wr_hit(CMD_MODE_CONFIG))
                device_mode_config <= cmd_wdata;
            if (wr_hit(CMD_TRIM_RATE))
                dac_trim_rate_divider <= cmd_wdata;
            if (wr_hit(CMD_MONITOR_RATE))
                monitor_rate_divider <= cmd_wdata;
            if (wr_hit(CMD_AVERAGING))
                averaging_config <= cmd_wdata;
        end
    end

    // Peak trackers; a host write wins over a same-cycle sample.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            voltage_peak_hold     <= PEAK_RESET;
            current_peak_hold     <= PEAK_RESET;
            temperature_peak_hold <= PEAK_RESET;
        end
        else
        begin
            if (wr_hit(CMD_VOLT_PEAK))
                voltage_peak_hold <= cmd_wdata;
            else if (meas_valid)
                voltage_peak_hold <= peak_of(voltage_peak_hold,
                                             meas_voltage, 1'b0);
            if (wr_hit(CMD_CURR_PEAK))
                current_peak_hold <= cmd_wdata;
            else if (meas_valid)
                current_peak_hold <= peak_of(current_peak_hold,
                                             meas_current, 1'b0);
            if (wr_hit(CMD_TEMP_PEAK))
                temperature_peak_hold <= (cmd_wdata == TEMP_PEAK_CLEAR)
                    ? TEMP_PEAK_LOW : cmd_wdata;
            else if (meas_valid)
                temperature_peak_hold <= peak_of(temperature_peak_hold,
                                                 meas_temp, 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path; identity codes ignore writes because nothing stores them.
    logic [15:0] next_rdata;
    logic        next_ack;

    always_comb
    begin
        next_ack   = cmd_rd;
        next_rdata = 16'h0000;
        case (cmd_code)
            CMD_SPEC_REVISION:
                next_rdata = {8'h00, SPEC_PART1_REV, SPEC_PART2_REV};
            CMD_MAKER_CODE:    next_rdata = MAKER_CODE;
            CMD_MODEL_CODE:    next_rdata = MODEL_CODE;
            CMD_PART_REVISION:
            begin
                next_rdata = REVISION_TEXT;
                next_ack   = cmd_rd && cmd_block;
            end
            CMD_LINK_ECHO:     next_rdata = link_echo_word;
            CMD_MODE_CONFIG:   next_rdata = device_mode_config;
            CMD_TRIM_RATE:     next_rdata = dac_trim_rate_divider;
            CMD_MONITOR_RATE:  next_rdata = monitor_rate_divider;
            CMD_VOLT_PEAK:     next_rdata = voltage_peak_hold;
            CMD_CURR_PEAK:     next_rdata = current_peak_hold;
            CMD_TEMP_PEAK:     next_rdata = temperature_peak_hold;
            CMD_AVERAGING:     next_rdata = averaging_config;
            default:           next_rdata = 16'h0000;
        endcase
    end

    // Read data is registered; ack follows the read by one cycle.
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            cmd_rdata <= 16'h0000;
            cmd_ack   <= 1'b0;
        end
        else
        begin
            cmd_rdata <= next_ack ? next_rdata : 16'h0000;
            cmd_ack   <= next_ack;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared clock pin synchroniser and rising-edge detect.
    logic clk_pin_meta;
    logic clk_pin_sync;
    logic clk_pin_prev;
    logic onoff_meta;
    logic onoff_sync;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            clk_pin_meta <= 1'b0;
            clk_pin_sync <= 1'b0;
            clk_pin_prev <= 1'b0;
            onoff_meta   <= 1'b0;
            onoff_sync   <= 1'b0;
        end
        else
        begin
            clk_pin_meta <= shared_timebase_pin_in;
            clk_pin_sync <= clk_pin_meta;
            clk_pin_prev <= clk_pin_sync;
            onoff_meta   <= addr_or_power_switch_pin;
            onoff_sync   <= onoff_meta;
        end
    end

    logic       ext_selected;
    logic       ext_edge;
    logic [7:0] ext_factor;
    logic       ext_factor_ok;

    assign ext_selected  = device_mode_config[MODE_EXT_CLOCK];
    assign ext_edge      = clk_pin_sync && !clk_pin_prev;
    assign ext_factor    = device_mode_config[15:MODE_CLK_FACTOR_LSB];
    assign ext_factor_ok = (ext_factor >= 8'(EXT_FACTOR_MIN))
                        && (ext_factor <= 8'(EXT_FACTOR_MAX));

    ////////////////////////////////////////////////////////////////////////
    // 10kHz tick from the internal count or from external edges.
    logic [15:0] tick_cnt;
    logic        tick;
    logic [15:0] tick_limit;

    // External factor plus bias edges make one 100us period.
    assign tick_limit = ext_selected
        ? (16'(ext_factor) + 16'(EXT_FACTOR_BIAS) - 16'h0001)
        : 16'(TICK_CYCLES - 1);
    // Compare with >= so a count left above a smaller external limit,
    // after a source or factor change, wraps on the next counted edge instead of running
    // through the whole 16-bit range.
    assign tick = (tick_cnt >= tick_limit)
               && (!ext_selected || (ext_edge && ext_factor_ok));

    always_ff @(posedge core_clk)
    begin
        if (rst)
            tick_cnt <= 16'h0000;
        else if (tick)
            tick_cnt <= 16'h0000;
        else if (!ext_selected)
            tick_cnt <= tick_cnt + 16'h0001;
        else if (ext_edge && ext_factor_ok)
            tick_cnt <= tick_cnt + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Trim and monitor dividers; zero stops the pulses.
    logic [15:0] trim_cnt;
    logic [15:0] mon_cnt;

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            trim_cnt  <= 16'h0000;
            trim_step <= 1'b0;
        end
        else
        begin
            trim_step <= 1'b0;
            if (dac_trim_rate_divider == 16'h0000 || !in_regulation)
                trim_cnt <= 16'h0000;
            else if (tick)
            begin
                if (trim_cnt + 16'h0001 >= dac_trim_rate_divider)
                begin
                    trim_cnt  <= 16'h0000;
                    trim_step <= 1'b1;
                end
                else
                    trim_cnt <= trim_cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            mon_cnt      <= 16'h0000;
            monitor_tick <= 1'b0;
        end
        else
        begin
            monitor_tick <= 1'b0;
            if (monitor_rate_divider == 16'h0000)
                mon_cnt <= 16'h0000;
            else if (tick)
            begin
                if (mon_cnt + 16'h0001 >= monitor_rate_divider)
                begin
                    mon_cnt      <= 16'h0000;
                    monitor_tick <= 1'b1;
                end
                else
                    mon_cnt <= mon_cnt + 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // 1MHz reference clock out; never while the pin is an input.
    logic [7:0] ref_cnt;
    logic       ref_level;
    logic       ref_enable;

    assign ref_enable = device_mode_config[MODE_CLK_OUT] && !ext_selected;

    always_ff @(posedge core_clk)
    begin
        if (rst || !ref_enable)
        begin
            ref_cnt   <= 8'h00;
            ref_level <= 1'b0;
        end
        else if (ref_cnt == 8'(REFCLK_HALF - 1))
        begin
            ref_cnt   <= 8'h00;
            ref_level <= !ref_level;
        end
        else
            ref_cnt <= ref_cnt + 8'h01;
    end

    assign shared_timebase_pin_out = ref_level;
    assign shared_timebase_pin_oe  = ref_enable;

    ////////////////////////////////////////////////////////////////////////
    // Supply enable, store lock and mode outputs.
    logic supply_on;

    assign supply_on = operation_on
        && (!device_mode_config[MODE_PIN_ONOFF] || onoff_sync);
    // Polarity set: on-state is high; clear: off-state is high.
    assign supply_enable_output = device_mode_config[MODE_EN_POLARITY]
        ? supply_on : !supply_on;
    assign eeprom_store_go = store_all_req
        && !device_mode_config[MODE_STORE_LOCK];
    assign eeprom_restore_go = restore_all_req;
    assign corr_bypass    = device_mode_config[MODE_CORR_BYPASS];
    assign range_high     = device_mode_config[MODE_RANGE_HIGH];
    assign feedback_mode  = device_mode_config[MODE_FEEDBACK];
    assign avg_delay_code = averaging_config[15:8];
    assign avg_count_exp  = averaging_config[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Assertions.
    echo_capture_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr |=> link_echo_word == $past(cmd_wdata))
        else $error("echo word missed a write");
    mode_reset_a: assert property (@(posedge core_clk)
        rst |=> device_mode_config == 16'h0000)
        else $error("mode word not zero after reset");
    store_lock_a: assert property (@(posedge core_clk) disable iff (rst)
        device_mode_config[MODE_STORE_LOCK] |-> !eeprom_store_go)
        else $error("store started while locked");
    revision_block_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_rd && !cmd_block && cmd_code == CMD_PART_REVISION
        |=> !cmd_ack)
        else $error("revision answered a plain read");
    spec_rev_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_rd && cmd_code == CMD_SPEC_REVISION
        |=> cmd_rdata == 16'h0000)
        else $error("spec revision wrong");
    volt_clear_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr && cmd_code == CMD_VOLT_PEAK && cmd_wdata == 16'h0000
        |=> voltage_peak_hold == 16'h0000)
        else $error("voltage peak not cleared");
    curr_peak_a: assert property (@(posedge core_clk) disable iff (rst)
        meas_valid && !cmd_wr |=> current_peak_hold >= $past(meas_current))
        else $error("current peak below sample");
    temp_reset_a: assert property (@(posedge core_clk) disable iff (rst)
        cmd_wr && cmd_code == CMD_TEMP_PEAK && cmd_wdata == 16'hffff
        |=> temperature_peak_hold == 16'h8000)
        else $error("temperature peak not lowest");
    mon_off_a: assert property (@(posedge core_clk) disable iff (rst)
        monitor_rate_divider == 16'h0000 [*2] |-> !monitor_tick)
        else $error("monitor tick while disabled");
    trim_off_a: assert property (@(posedge core_clk) disable iff (rst)
        !in_regulation [*2] |-> !trim_step)
        else $error("trim step outside regulation");
    ref_drive_a: assert property (@(posedge core_clk) disable iff (rst)
        !device_mode_config[MODE_CLK_OUT] |-> !shared_timebase_pin_oe)
        else $error("clock driven while disabled");
    enable_pol_a: assert property (@(posedge core_clk) disable iff (rst)
        !operation_on |-> supply_enable_output
            == !device_mode_config[MODE_EN_POLARITY])
        else $error("enable polarity wrong");
    int_tick_a: assert property (@(posedge core_clk) disable iff (rst)
        tick && !ext_selected |=> !tick [*8])
        else $error("internal tick too fast");
    echo_cov: cover property (@(posedge core_clk)
        wr_hit(CMD_LINK_ECHO) ##[1:20] cmd_rd && cmd_code == CMD_LINK_ECHO);
    ext_cov: cover property (@(posedge core_clk) ext_selected && tick);
    mon_cov: cover property (@(posedge core_clk) monitor_tick);
    refclk_cov: cover property (@(posedge core_clk) shared_timebase_pin_oe);

endmodule

// file: bench/pmc_host.sv
// Host master model that issues word writes and word or block reads to the bank.
`timescale 1ns/1ps
module pmc_host
(
    // Clock.
    input  wire logic        core_clk,
    // Command port towards the bank.
    output logic             cmd_wr,
    output logic             cmd_rd,
    output logic             cmd_block,
    output logic [7:0]       cmd_code,
    output logic [15:0]      cmd_wdata,
    input  wire logic [15:0] cmd_rdata,
    input  wire logic        cmd_ack
);
    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero.
    initial
    begin
        {cmd_wr, cmd_rd, cmd_block, cmd_code, cmd_wdata} = '0;
    end

    // Word write; stale data is inverted after release so it is never reused.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(negedge core_clk);
        cmd_code = c;
        cmd_wdata = d;
        cmd_wr = 1'b1;
        @(negedge core_clk);
        cmd_wr = 1'b0;
        cmd_wdata = ~d;
    endtask

    // Word or block read; the answer stands for one cycle after the take.
    task automatic rd(input logic [7:0] c, input logic blk,
                      output logic [15:0] d, output logic ok);
        @(negedge core_clk);
        cmd_code = c;
        cmd_block = blk;
        cmd_rd = 1'b1;
        @(negedge core_clk);
        cmd_rd = 1'b0;
        cmd_block = 1'b0;
        ok = (cmd_ack === 1'b1);
        d = cmd_rdata;
    endtask
endmodule

// file: bench/tb.sv
// Self-checking testbench for the command register bank.
`timescale 1ns/1ps
module tb
    import pmc_pkg::*;
;
    // Identity values are arbitrary.
    localparam logic [15:0] MK = 16'h2a5c;
    localparam logic [15:0] MD = 16'h6b3d;
    localparam logic [15:0] RV = 16'h4e31;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        link_on = 1'b0;
    logic        link_clk = 1'b0;
    logic        cmd_wr, cmd_rd, cmd_block, cmd_ack, ok;
    logic [7:0]  cmd_code, adc, ace;
    logic [15:0] cmd_wdata, cmd_rdata, rv;
    logic        st_req = 1'b0, rs_req = 1'b0, st_go, rs_go, mv = 1'b0;
    logic [15:0] mvolt = 16'h0000, mcur = 16'h0000, mtmp = 16'h0000;
    logic        op_on = 1'b0, in_reg = 1'b0, en, trim_step, mon_tick;
    logic        tb_out, tb_oe, pin_sw = 1'b0, corr, rng, fbm;
    int          err_total = 0, checks = 0, cyc = 0;
    // The shared pin carries our drive or else the bench link clock.
    wire         tb_pin = tb_oe ? tb_out : link_clk;

    ////////////////////////////////////////////////////////////////////////
    pmc_command_bank #(.MAKER_CODE(MK), .MODEL_CODE(MD), .REVISION_TEXT(RV))
    dut (.core_clk(core_clk), .rst(rst), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_block(cmd_block), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .store_all_req(st_req),
        .restore_all_req(rs_req), .eeprom_store_go(st_go),
        .eeprom_restore_go(rs_go), .meas_valid(mv), .meas_voltage(mvolt),
        .meas_current(mcur), .meas_temp(mtmp), .operation_on(op_on),
        .in_regulation(in_reg), .supply_enable_output(en),
        .trim_step(trim_step), .monitor_tick(mon_tick),
        .shared_timebase_pin_in(tb_pin), .shared_timebase_pin_out(tb_out),
        .shared_timebase_pin_oe(tb_oe), .addr_or_power_switch_pin(pin_sw),
        .corr_bypass(corr), .range_high(rng), .feedback_mode(fbm),
        .avg_delay_code(adc), .avg_count_exp(ace));
    pmc_host host (.core_clk(core_clk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_block(cmd_block), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack));

    ////////////////////////////////////////////////////////////////////////
    // Core clock, and a link clock that stands still when not needed.
    always #50 core_clk = ~core_clk;
    initial
    begin
        #17;
        forever #400 if (link_on) link_clk = ~link_clk;
    end

    // Cycle ceiling so a hang still ends in the report.
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            err_total++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic rc(input string nm, input logic [7:0] c, logic [15:0] e);
        host.rd(c, 1'b0, rv, ok);
        chk(nm, e, rv);
    endtask

    task automatic meas(input logic [15:0] v, i, t);
        @(negedge core_clk);
        {mvolt, mcur, mtmp, mv} = {v, i, t, 1'b1};
        @(negedge core_clk);
        mv = 1'b0;
    endtask

    // Cycles between the second and third rising edge of a pulse source;
    // the first edge is skipped as it may follow an older setting.
    task automatic gap(input int sel, output logic [15:0] g);
        logic p, c;
        int   k, t;
        {p, k, t, g} = '0;
        while (k < 3 && t < 10000)
        begin
            @(negedge core_clk);
            t++;
            c = sel == 0 ? mon_tick : sel == 1 ? trim_step : tb_out;
            if (c === 1'b1 && p !== 1'b1) k++;
            if (k == 2) g++;
            p = c;
        end
    endtask

    task automatic quiet(input int n, output logic [15:0] c);
        c = '0;
        repeat (n)
        begin
            @(negedge core_clk);
            if (mon_tick === 1'b1 || trim_step === 1'b1) c++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rc("mode", CMD_MODE_CONFIG, 16'h0000);
        rc("trim rate", CMD_TRIM_RATE, 16'h000a);
        rc("mon rate", CMD_MONITOR_RATE, 16'h0032);
        rc("vpeak", CMD_VOLT_PEAK, 16'h0000);
        rc("ipeak", CMD_CURR_PEAK, 16'h0000);
        chk("clk oe", 16'h0000, {15'h0, tb_oe});
        $display("test reset done");
    endtask

    task automatic t_ident;
        rc("spec rev", CMD_SPEC_REVISION, 16'h0000);
        host.wr(CMD_MAKER_CODE, 16'hbeef);
        host.wr(CMD_MODEL_CODE, 16'hbeef);
        rc("maker", CMD_MAKER_CODE, MK);
        rc("model", CMD_MODEL_CODE, MD);
        host.rd(CMD_PART_REVISION, 1'b0, rv, ok);
        chk("rev word ack", 16'h0000, {15'h0, ok});
        host.rd(CMD_PART_REVISION, 1'b1, rv, ok);
        chk("rev text", RV, rv);
        $display("test ident done");
    endtask

    task automatic t_echo;
        host.wr(CMD_LINK_ECHO, 16'h1357);
        rc("echo", CMD_LINK_ECHO, 16'h1357);
        host.wr(CMD_AVERAGING, 16'h0305);
        rc("echo other", CMD_LINK_ECHO, 16'h0305);
        chk("avg fields", 16'h0305, {adc, ace});
        $display("test echo done");
    endtask

    task automatic t_mode;
        logic [15:0] g;
        host.wr(CMD_MODE_CONFIG, 16'h001a);
        chk("mode bits", 16'h0007, {13'h0, corr, rng, fbm});
        op_on = 1'b1;
        #1 chk("en pol0", 16'h0000, {15'h0, en});
        host.wr(CMD_MODE_CONFIG, 16'h0044);
        repeat (3) @(negedge core_clk);
        chk("pin off", 16'h0000, {15'h0, en});
        pin_sw = 1'b1;
        repeat (3) @(negedge core_clk);
        chk("pin on", 16'h0001, {15'h0, en});
        host.wr(CMD_MODE_CONFIG, 16'h0020);
        {st_req, rs_req} = 2'b11;
        #1 chk("store lock", 16'h0001, {14'h0, st_go, rs_go});
        @(negedge core_clk) {st_req, rs_req} = 2'b00;
        pin_sw = 1'b0;
        host.wr(CMD_MODE_CONFIG, 16'h0004);
        repeat (3) @(negedge core_clk);
        st_req = 1'b1;
        #1 chk("pin ignored, store", 16'h0003, {14'h0, en, st_go});
        @(negedge core_clk) st_req = 1'b0;
        host.wr(CMD_MODE_CONFIG, 16'h0080);
        chk("clk out oe", 16'h0001, {15'h0, tb_oe});
        gap(2, g);
        chk("clk out period", 16'h000a, g);
        host.wr(CMD_MODE_CONFIG, 16'h0000);
        chk("clk out off", 16'h0000, {15'h0, tb_oe});
        $display("test mode done");
    endtask

    task automatic t_peak;
        meas(16'h0100, 16'h0050, 16'h0020);
        meas(16'h0080, 16'h0010, 16'h0010);
        rc("vpeak max", CMD_VOLT_PEAK, 16'h0100);
        rc("ipeak max", CMD_CURR_PEAK, 16'h0050);
        rc("tpeak max", CMD_TEMP_PEAK, 16'h0020);
        host.wr(CMD_VOLT_PEAK, 16'h0000);
        host.wr(CMD_CURR_PEAK, 16'h0200);
        host.wr(CMD_TEMP_PEAK, 16'hffff);
        meas(16'h0040, 16'h0150, 16'hfff0);
        rc("vpeak clear", CMD_VOLT_PEAK, 16'h0040);
        rc("ipeak base", CMD_CURR_PEAK, 16'h0200);
        rc("tpeak low", CMD_TEMP_PEAK, 16'hfff0);
        $display("test peak done");
    endtask

    task automatic t_rate;
        logic [15:0] g;
        host.wr(CMD_MONITOR_RATE, 16'h0002);
        host.wr(CMD_TRIM_RATE, 16'h0003);
        gap(0, g);
        chk("mon gap", 16'h07d0, g);
        in_reg = 1'b1;
        gap(1, g);
        chk("trim gap", 16'h0bb8, g);
        in_reg = 1'b0;
        host.wr(CMD_MONITOR_RATE, 16'h0000);
        quiet(3500, g);
        chk("no ticks", 16'h0000, g);
        $display("test rate done");
    endtask

    task automatic t_ext;
        logic [15:0] g;
        host.wr(CMD_MONITOR_RATE, 16'h0001);
        host.wr(CMD_MODE_CONFIG, 16'h0881);
        link_on = 1'b1;
        chk("ext oe", 16'h0000, {15'h0, tb_oe});
        gap(0, g);
        chk("ext gap", 16'h0050, g);
        host.wr(CMD_MODE_CONFIG, 16'h0701);
        repeat (4) @(negedge core_clk);
        quiet(1200, g);
        chk("ext bad factor", 16'h0000, g);
        link_on = 1'b0;
        $display("test ext done");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; peaks run before monitoring is switched off.
    initial
    begin
        repeat (4) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_ident();
        t_echo();
        t_mode();
        t_peak();
        t_rate();
        t_ext();
        report_and_stop();
    end
endmodule
